// file: rtl/aslis_pkg.sv
/*
 Package for the four-axis soft limit and interrupt cause block: register map,
 cause bit positions, reset values.
 Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package aslis_pkg;
   localparam int NUM_AXES = 4;
   localparam int POS_W    = 32;
   localparam int ADDR_W   = 12;

   // per-axis register block: base = axis * AXIS_STRIDE
   localparam logic [ADDR_W-1:0] AXIS_STRIDE    = 12'h040;
   localparam logic [ADDR_W-1:0] OFF_POS_LIMIT  = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_NEG_LIMIT  = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_LIMIT_CTRL = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_EVT_CAUSE  = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_EVT_MASK   = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_FLT_CAUSE  = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_GLOBAL     = 12'h100;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT   = 12'h104;

   // limit control fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_DECEL_BIT  = 1;

   // implemented cause bits
   localparam logic [31:0] EVT_VALID_MASK = 32'h0005DCF7;
   localparam logic [31:0] FLT_VALID_MASK = 32'h0003F7EB;
   localparam logic [31:0] EVT_AXIS01_ONLY = 32'h00001000;
   localparam logic [31:0] EVT_AXIS23_ONLY = 32'h00004000;

   localparam int FLT_POS_SOFT = 0;
   localparam int FLT_NEG_SOFT = 1;

   localparam logic [31:0] RST_CAUSE = 32'h00000000;
   localparam logic [31:0] RST_MASK  = 32'h00000000;
   localparam logic [31:0] RST_LIMIT = 32'h00000000;
endpackage

// file: rtl/aslis_core.sv
/*
 Soft limit comparators and interrupt cause collection for four axes,
 with APB register access and one level interrupt output.
 Assumes command positions and cause strobes are synchronous to core_clk.
*/
// The APB interface to the registers and the address map were left to the implementer.
//Contract
// - each axis has positive and negative limit compare on command position only
// - reaching an enabled limit stops the axis, immediate or decelerating
// - host loads limit values and enables checking separately; stops only while enabled
// - limit values are positions relative to command counter zero
// - global enable decides whether any interrupt request is raised
// - per-axis event and fault cause words, both readable
// - each event cause bit individually enabled by host mask
// - every fault cause requests interrupt, unmaskable, under global enable
// - event bits 0,1,2,4-7 normal motion events
// - event bits 10,11,12 out-of-step, general compare, trigger on axes 0-1
// - event bits 14 latch on axes 2-3, 15 home, 16 slowdown, 18 sync start
// - fault bits 0,1 soft limits, bit 3 general comparator stop
// - fault bits 5,6 end limits, bit 7 servo alarm
// - fault bits 8 sync stop, 9 emergency, 10 slowdown stop
// - fault bits 12,13,14 interpolation error, partner stop, pulser overflow
// - fault bits 15,16,17 interpolation overflow, encoder error, pulser error
`timescale 1ns/1ps
module aslis_core #(
   parameter int NUM_AXES = aslis_pkg::NUM_AXES
)(
   input  wire logic                          core_clk,
   input  wire logic                          nrst,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [aslis_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [NUM_AXES*32-1:0]        cmdPosition,
   input  wire logic [NUM_AXES*32-1:0]        eventStrobe,
   input  wire logic [NUM_AXES*32-1:0]        faultStrobe,
   output logic      [NUM_AXES-1:0]           stopNow,
   output logic      [NUM_AXES-1:0]           stopDecel,
   output logic                               irq
);
   initial
   begin
      if (NUM_AXES < 1 || NUM_AXES > 4)
         $error("NUM_AXES must be 1 to 4");
   end

   logic [31:0] posLimit   [NUM_AXES];
   logic [31:0] negLimit   [NUM_AXES];
   logic [1:0]  limitCtrl  [NUM_AXES];
   logic [31:0] eventCause [NUM_AXES];
   logic [31:0] eventMask  [NUM_AXES];
   logic [31:0] faultCause [NUM_AXES];
   logic        global_irq_enable;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic [NUM_AXES-1:0] axisIrq;
   logic [NUM_AXES-1:0] posHit;
   logic [NUM_AXES-1:0] negHit;

   wire logic access = psel && penable;
   wire logic wrAcc  = access && pwrite;
   wire logic rdAcc  = access && !pwrite;

   // axis index of an address, or NUM_AXES when outside the axis blocks
   function automatic int axisOf(input logic [aslis_pkg::ADDR_W-1:0] a);
      int idx;
      idx = int'(a[aslis_pkg::ADDR_W-1:6]);
      if (idx < NUM_AXES)
         return idx;
      return NUM_AXES;
   endfunction

   function automatic logic [31:0] strobeMerge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (s[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      return r;
   endfunction

   function automatic logic [31:0] evtValid(input int ax);
      logic [31:0] m;
      m = aslis_pkg::EVT_VALID_MASK;
      if (ax > 1)
         m = m & ~aslis_pkg::EVT_AXIS01_ONLY;
      if (ax < 2)
         m = m & ~aslis_pkg::EVT_AXIS23_ONLY;
      return m;
   endfunction

   assign pready = 1'b1;

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++)
      begin : gAxis
         logic [31:0] pos;
         logic        selAxis;
         logic [5:0]  off;
         logic [31:0] next_posLimit;
         logic [31:0] next_negLimit;
         logic [1:0]  next_limitCtrl;
         logic [31:0] next_eventCause;
         logic [31:0] next_eventMask;
         logic [31:0] next_faultCause;
         logic        next_stopNow;
         logic        next_stopDecel;
         logic        rdEvt;
         logic        rdFlt;

         assign pos     = cmdPosition[g*32 +: 32];
         assign selAxis = (axisOf(paddr) == g);
         assign off     = paddr[5:0];
         assign rdEvt   = rdAcc && selAxis && off == aslis_pkg::OFF_EVT_CAUSE[5:0];
         assign rdFlt   = rdAcc && selAxis && off == aslis_pkg::OFF_FLT_CAUSE[5:0];

         // signed compare, both limits share the command counter zero
         assign posHit[g] = limitCtrl[g][aslis_pkg::CTRL_ENABLE_BIT]
                            && $signed(pos) >= $signed(posLimit[g]);
         assign negHit[g] = limitCtrl[g][aslis_pkg::CTRL_ENABLE_BIT]
                            && $signed(pos) <= $signed(negLimit[g]);

         always_comb
         begin
            next_posLimit   = posLimit[g];
            next_negLimit   = negLimit[g];
            next_limitCtrl  = limitCtrl[g];
            next_eventMask  = eventMask[g];
            if (wrAcc && selAxis)
            begin
               case (off)
                  aslis_pkg::OFF_POS_LIMIT[5:0]:  next_posLimit = strobeMerge(posLimit[g], pwdata, pstrb);
                  aslis_pkg::OFF_NEG_LIMIT[5:0]:  next_negLimit = strobeMerge(negLimit[g], pwdata, pstrb);
                  aslis_pkg::OFF_LIMIT_CTRL[5:0]: if (pstrb[0]) next_limitCtrl = pwdata[1:0];
                  aslis_pkg::OFF_EVT_MASK[5:0]:
                     next_eventMask = strobeMerge(eventMask[g], pwdata, pstrb) & evtValid(g);
                  default: ;
               endcase
            end
            // read clears, a new event in the same cycle survives
            next_eventCause = (rdEvt ? 32'h00000000 : eventCause[g])
                              | (eventStrobe[g*32 +: 32] & evtValid(g));
            next_faultCause = (rdFlt ? 32'h00000000 : faultCause[g])
                              | (faultStrobe[g*32 +: 32] & aslis_pkg::FLT_VALID_MASK);
            next_faultCause[aslis_pkg::FLT_POS_SOFT] = next_faultCause[aslis_pkg::FLT_POS_SOFT] | posHit[g];
            next_faultCause[aslis_pkg::FLT_NEG_SOFT] = next_faultCause[aslis_pkg::FLT_NEG_SOFT] | negHit[g];
            // handled through FLT_VALID_MASK
            // soft limit behaves like end limit: immediate or decelerate
            next_stopNow   = (posHit[g] || negHit[g]) && !limitCtrl[g][aslis_pkg::CTRL_DECEL_BIT];
            next_stopDecel = (posHit[g] || negHit[g]) &&  limitCtrl[g][aslis_pkg::CTRL_DECEL_BIT];
         end

         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               posLimit[g]   <= aslis_pkg::RST_LIMIT;
               negLimit[g]   <= aslis_pkg::RST_LIMIT;
               limitCtrl[g]  <= 2'h0;
               eventCause[g] <= aslis_pkg::RST_CAUSE;
               eventMask[g]  <= aslis_pkg::RST_MASK;
               faultCause[g] <= aslis_pkg::RST_CAUSE;
               stopNow[g]    <= 1'b0;
               stopDecel[g]  <= 1'b0;
            end
            else
            begin
               posLimit[g]   <= next_posLimit;
               negLimit[g]   <= next_negLimit;
               limitCtrl[g]  <= next_limitCtrl;
               eventCause[g] <= next_eventCause;
               eventMask[g]  <= next_eventMask;
               faultCause[g] <= next_faultCause;
               stopNow[g]    <= next_stopNow;
               stopDecel[g]  <= next_stopDecel;
            end
         end

         // fault bits are never masked
         assign axisIrq[g] = |(eventCause[g] & eventMask[g]) || |faultCause[g];
      end
   endgenerate

   logic next_global;
   always_comb
   begin
      next_global = global_irq_enable;
      if (wrAcc && paddr == aslis_pkg::OFF_GLOBAL && pstrb[0])
         next_global = pwdata[0];
   end

   always_comb
   begin
      int ax;
      ax = axisOf(paddr);
      next_prdata  = 32'h00000000;
      next_pslverr = 1'b0;
      if (ax < NUM_AXES)
      begin
         case (paddr[5:0])
            aslis_pkg::OFF_POS_LIMIT[5:0]:  next_prdata = posLimit[ax];
            aslis_pkg::OFF_NEG_LIMIT[5:0]:  next_prdata = negLimit[ax];
            aslis_pkg::OFF_LIMIT_CTRL[5:0]: next_prdata = {30'h00000000, limitCtrl[ax]};
            aslis_pkg::OFF_EVT_CAUSE[5:0]:  next_prdata = eventCause[ax];
            aslis_pkg::OFF_EVT_MASK[5:0]:   next_prdata = eventMask[ax];
            aslis_pkg::OFF_FLT_CAUSE[5:0]:  next_prdata = faultCause[ax];
            default:                        next_pslverr = 1'b1;
         endcase
      end
      else if (paddr == aslis_pkg::OFF_GLOBAL)
         next_prdata = {31'h00000000, global_irq_enable};
      else if (paddr == aslis_pkg::OFF_IRQ_STAT)
         next_prdata = {{(32-NUM_AXES){1'b0}}, axisIrq};
      else
         next_pslverr = 1'b1;
   end

   // read data is combinational off registers, valid in the access phase
   assign prdata  = access ? next_prdata : 32'h00000000;
   assign pslverr = access && next_pslverr;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         global_irq_enable <= 1'b0;
         irq               <= 1'b0;
      end
      else
      begin
         global_irq_enable <= next_global;
         irq               <= global_irq_enable && |axisIrq;
      end
   end

   // assertions
   property p_softStop;
      @(posedge core_clk) disable iff (!nrst)
      (posHit[0] || negHit[0]) |=> (stopNow[0] || stopDecel[0]);
   endproperty
   a_softStop: assert property (p_softStop) else $error("limit hit without stop");

   property p_noStopDisabled;
      @(posedge core_clk) disable iff (!nrst)
      !limitCtrl[0][aslis_pkg::CTRL_ENABLE_BIT] |=> !(stopNow[0] || stopDecel[0]);
   endproperty
   a_noStopDisabled: assert property (p_noStopDisabled) else $error("stop while checking off");

   property p_posFault;
      @(posedge core_clk) disable iff (!nrst)
      posHit[0] |=> faultCause[0][aslis_pkg::FLT_POS_SOFT];
   endproperty
   a_posFault: assert property (p_posFault) else $error("positive limit fault not recorded");

   property p_globalGate;
      @(posedge core_clk) disable iff (!nrst)
      !global_irq_enable |=> !irq;
   endproperty
   a_globalGate: assert property (p_globalGate) else $error("irq without global enable");

   property p_faultIrq;
      @(posedge core_clk) disable iff (!nrst)
      (global_irq_enable && |faultCause[0]) |=> irq;
   endproperty
   a_faultIrq: assert property (p_faultIrq) else $error("fault did not raise irq");

   property p_maskedEvt;
      @(posedge core_clk) disable iff (!nrst)
      (axisIrq == '0) |=> !irq;
   endproperty
   a_maskedEvt: assert property (p_maskedEvt) else $error("irq with no enabled cause");

   property p_reserved;
      @(posedge core_clk) disable iff (!nrst)
      ((eventCause[0] & ~aslis_pkg::EVT_VALID_MASK) == '0) && ((faultCause[0] & ~aslis_pkg::FLT_VALID_MASK) == '0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved cause bit set");

   property p_sticky;
      @(posedge core_clk) disable iff (!nrst)
      (eventCause[0][0] && !(rdAcc && paddr == aslis_pkg::OFF_EVT_CAUSE)) |=> eventCause[0][0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("event bit lost without read");

   property p_readClear;
      @(posedge core_clk) disable iff (!nrst)
      (rdAcc && paddr == aslis_pkg::OFF_EVT_CAUSE && eventStrobe[0] == 1'b0) |=> !eventCause[0][0];
   endproperty
   a_readClear: assert property (p_readClear) else $error("read did not clear event bit");
endmodule

// file: tb/aslis_host_model.sv
/*
 Host side model: APB master for register reads and writes.
 Assumes one core_clk domain; each call starts right after a rising edge.
*/
`timescale 1ns/1ps
module aslis_host_model (
   input  wire logic        core_clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic        pready,
   output logic             hangSeen
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      hangSeen = 1'b0;
   end

   // host loads limits, enables, mask and global flag through this
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
         hangSeen <= 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps strobes from being assigned twice in one step
      @(posedge core_clk);
   endtask
endmodule

// file: tb/tb_axis_soft_limit_and_interrupt_status.sv
/*
 Self-checking bench: register reset values, cause words, interrupt, soft limits.
 Assumes zero-wait APB slave and read-clear cause words.
*/
`timescale 1ns/1ps
module tb_axis_soft_limit_and_interrupt_status;
   localparam int NA = aslis_pkg::NUM_AXES;
   logic              core_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, hangSeen;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic [NA*32-1:0]  cmdPosition, eventStrobe, faultStrobe;
   logic [NA-1:0]     stopNow, stopDecel;
   logic [32:0]       notes[$];
   int                err_total, n_checks;

   aslis_core #(.NUM_AXES(NA)) i_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmdPosition(cmdPosition), .eventStrobe(eventStrobe), .faultStrobe(faultStrobe),
      .stopNow(stopNow), .stopDecel(stopDecel), .irq(irq));
   aslis_host_model i_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .hangSeen(hangSeen));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read results compared against the oldest note
   always @(posedge core_clk)
   begin
      if (hangSeen === 1'b1)
      begin
         err_total++;
         tally_and_finish();
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
         chk({pslverr, prdata}, notes.pop_front());
   end

   function automatic logic [11:0] ra(input int ax, input logic [11:0] off);
      return 12'(ax) * aslis_pkg::AXIS_STRIDE + off;
   endfunction

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      notes.push_back(e);
      i_host.xfer(1'b0, a, 32'h00000000);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
   endtask

   task automatic pulse(input int ax, input logic [31:0] ev, input logic [31:0] fl);
      eventStrobe[ax*32 +: 32] <= ev;
      faultStrobe[ax*32 +: 32] <= fl;
      @(posedge core_clk);
      eventStrobe <= '0;
      faultStrobe <= '0;
      @(posedge core_clk);
   endtask

   // {stopDecel, stopNow, irq} after n edges, looked at mid-cycle
   task automatic outs(input int n, input logic [8:0] e);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
      chk({24'h0, stopDecel, stopNow, irq}, {24'h0, e});
      @(posedge core_clk);
   endtask

   initial
   begin
      int ax;
      int p;
      int n;
      logic [31:0] ev;
      logic [31:0] fl;
      nrst = 1'b0;
      cmdPosition = '0;
      eventStrobe = '0;
      faultStrobe = '0;
      err_total = 0;
      n_checks = 0;
      void'($urandom(82950));
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      for (int a = 0; a < NA; a++)
         for (int o = 0; o < 6; o++)
            rd(ra(a, 12'(o * 4)), 33'h0);
      rd(aslis_pkg::OFF_GLOBAL, 33'h0);
      rd(12'h018, 33'h100000000);
      $display("test reset values done");
      for (int a = 0; a < NA; a++)
      begin
         ev = $urandom | aslis_pkg::EVT_VALID_MASK;
         fl = $urandom | aslis_pkg::FLT_VALID_MASK;
         pulse(a, ev, fl);
         wr(ra(a, aslis_pkg::OFF_EVT_CAUSE), 32'hFFFFFFFF);
         ev = ev & aslis_pkg::EVT_VALID_MASK & ((a < 2) ? ~aslis_pkg::EVT_AXIS23_ONLY : ~aslis_pkg::EVT_AXIS01_ONLY);
         rd(ra(a, aslis_pkg::OFF_EVT_CAUSE), {1'b0, ev});
         rd(ra(a, aslis_pkg::OFF_EVT_CAUSE), 33'h0);
         rd(ra(a, aslis_pkg::OFF_FLT_CAUSE), {1'b0, fl & aslis_pkg::FLT_VALID_MASK});
         rd(ra(a, aslis_pkg::OFF_FLT_CAUSE), 33'h0);
         outs(1, 9'h000);
      end
      $display("test cause words done");
      wr(aslis_pkg::OFF_GLOBAL, 32'h00000001);
      pulse(1, 32'h00000001, 32'h0);
      outs(2, 9'h000);
      wr(ra(1, aslis_pkg::OFF_EVT_MASK), 32'h00000001);
      outs(2, 9'h001);
      rd(ra(1, aslis_pkg::OFF_EVT_CAUSE), 33'h1);
      outs(2, 9'h000);
      pulse(3, 32'h0, 32'h00000020);
      outs(2, 9'h001);
      wr(aslis_pkg::OFF_GLOBAL, 32'h00000000);
      outs(2, 9'h000);
      rd(ra(3, aslis_pkg::OFF_FLT_CAUSE), 33'h20);
      $display("test interrupt done");
      ax = $urandom_range(NA - 1, 0);
      p = $urandom_range(5000, 100);
      n = $urandom_range(5000, 100);
      wr(ra(ax, aslis_pkg::OFF_POS_LIMIT), 32'(p));
      wr(ra(ax, aslis_pkg::OFF_NEG_LIMIT), 32'(-n));
      cmdPosition[ax*32 +: 32] <= 32'(p);
      outs(2, 9'h000);
      wr(ra(ax, aslis_pkg::OFF_LIMIT_CTRL), 32'h00000001);
      outs(2, 9'(2 << ax));
      cmdPosition[ax*32 +: 32] <= 32'(p - 1);
      outs(2, 9'h000);
      rd(ra(ax, aslis_pkg::OFF_FLT_CAUSE), 33'h1);
      wr(ra(ax, aslis_pkg::OFF_LIMIT_CTRL), 32'h00000003);
      cmdPosition[ax*32 +: 32] <= 32'(-n);
      outs(2, 9'(32 << ax));
      cmdPosition[ax*32 +: 32] <= 32'(1 - n);
      outs(2, 9'h000);
      rd(ra(ax, aslis_pkg::OFF_FLT_CAUSE), 33'h2);
      $display("test soft limits done");
      tally_and_finish();
   end
endmodule
